// ==== power_state_pkg.sv ====
//////////////////////////////////////////////////////////////////////////////////////////////////
package power_state_pkg;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned PME_PULSE_MS     = 50;
  localparam int unsigned RESUME_MAX_MS    = 2;
  localparam int unsigned PME_PULSE_CYCLES = CLK_HZ / 1000 * PME_PULSE_MS;
  localparam int unsigned RESUME_CYCLES    = CLK_HZ / 1000 * RESUME_MAX_MS;
  localparam int          PULSE_W          = 21;
  localparam int          RESUME_W         = 16;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam int          ADDR_W          = 12;
  localparam logic [11:0] ADDR_PMC        = 12'h000;
  localparam logic [11:0] ADDR_BYTE_TEST  = 12'h004;
  localparam logic [11:0] ADDR_INTERRUPT_STATUS_REG    = 12'h008;
  localparam logic [11:0] ADDR_PHY_CTRL   = 12'h00C;

  localparam int PMC_READY_BIT     = 0;
  localparam int PMC_PME_EN_BIT    = 1;
  localparam int PMC_PULSE_SEL_BIT = 3;
  localparam int PMC_WAKE_STATUS_FIELD_LSB      = 4;
  localparam int PMC_WAKE_ON_LAN_ENABLE_BIT    = 9;
  localparam int PMC_ENERGY_DETECT_WAKE_ENABLE_BIT     = 10;
  localparam int PMC_MODE_LSB      = 12;
  localparam int INT_PME_BIT       = 0;
  localparam int PHY_EDPD_BIT      = 0;

  localparam logic [1:0] MODE_D0   = 2'h0;
  localparam logic [1:0] MODE_D1   = 2'h1;
  localparam logic [1:0] MODE_D2   = 2'h2;
  localparam logic [1:0] WAKE_STATUS_FIELD_NONE = 2'h0;
  localparam logic [1:0] WAKE_STATUS_FIELD_ED   = 2'h1;
  localparam logic [1:0] WAKE_STATUS_FIELD_WOL  = 2'h2;

  // Arbitrary pattern, not tied to any part
  localparam logic [31:0] BYTE_TEST_VALUE = 32'h5A5A_C3C3;

  localparam int SYNC_W = 3;

  typedef enum logic [1:0] {
    pwr_d0,
    pwr_d1,
    pwr_d2,
    pwr_resume
  } pwr_state_t;

endpackage

// ==== wake_sync_if.sv ====
interface wake_sync_if;
  import power_state_pkg::*;
  logic [SYNC_W-1:0] level;
  modport producer (output level);
  modport consumer (input level);
endinterface

// ==== input_sync.sv ====
module input_sync
  import power_state_pkg::*;
(
  input wire logic              sys_clk,
  input wire logic              rst_n,
  input wire logic [SYNC_W-1:0] raw,
  wake_sync_if.producer         synced
);

  logic [SYNC_W-1:0] meta_q;
  logic [SYNC_W-1:0] stable_q;

  // First stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      stable_q <= '0;
    end else begin
      meta_q   <= raw;
      stable_q <= meta_q;
    end
  end

  assign synced.level = stable_q;

endmodule

// ==== power_state_wake_control.sv ====
module power_state_wake_control
  import power_state_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PME_PULSE_CYCLES,
  parameter int unsigned RESUME_LEN   = RESUME_CYCLES
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              wake_frame_det,
  input  wire logic              magic_pkt_det,
  input  wire logic              carrier_det,
  output logic                   pme_out,
  output logic                   mac_clk_en,
  output logic                   host_if_clk_en,
  output logic                   rx_pm_clk_en,
  output logic                   internal_clk_en,
  output logic                   phy_full_on,
  output logic                   phy_energy_detect_powerdown
);

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Detector inputs come from the PHY side
  wake_sync_if det_if ();

  input_sync u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .raw     ({carrier_det, magic_pkt_det, wake_frame_det}),
    .synced  (det_if.producer)
  );

  logic frame_s;
  logic magic_s;
  logic carrier_s;

  assign frame_s   = det_if.level[0];
  assign magic_s   = det_if.level[1];
  assign carrier_s = det_if.level[2];

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // State and registers
  pwr_state_t          state_q;
  logic                ready_q;
  logic [1:0]          power_mode_q;
  logic                read_seen_q;
  logic [RESUME_W-1:0] resume_cnt_q;
  logic                pme_en_q;
  logic                wake_pin_pulse_select_q;
  logic                wake_on_lan_enable_q;
  logic                energy_detect_wake_enable_q;
  logic [1:0]          wake_status_field_q;
  logic                pme_int_q;
  logic                edpd_q;
  logic                pme_irq_prev_q;
  logic [PULSE_W-1:0]  pulse_cnt_q;
  logic                pme_out_q;
  logic [31:0]         prdata_q;
  logic                err_q;
  logic                ignore_q;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // APB decode
  logic setup;
  logic wr_fire;
  logic rd_fire;
  logic addr_known;
  logic read_ok;
  logic write_ok;
  logic wr_en;
  logic wr_pmc;
  logic wr_int;
  logic wr_phy;
  logic wake_wr;
  logic [1:0] req_mode;

  assign pready  = 1'b1;
  assign setup   = psel & ~penable;
  assign wr_fire = psel & penable & pwrite;
  assign rd_fire = psel & penable & ~pwrite;

  assign addr_known = (paddr == ADDR_PMC) | (paddr == ADDR_BYTE_TEST) |
                      (paddr == ADDR_INTERRUPT_STATUS_REG) | (paddr == ADDR_PHY_CTRL);
  assign read_ok    = addr_known & (ready_q | (paddr == ADDR_PMC));
  assign write_ok   = ready_q ? addr_known : (paddr == ADDR_BYTE_TEST);

  // Flags are frozen at setup so a ready edge mid-transfer cannot split the answer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= '0;
      err_q    <= 1'b0;
      ignore_q <= 1'b0;
    end else if (setup) begin
      err_q    <= pwrite ? ~write_ok : ~read_ok;
      ignore_q <= ready_q & ~read_seen_q;
      prdata_q <= (!pwrite && read_ok) ? read_mux(paddr) : '0;
    end
  end

  assign prdata  = prdata_q;
  assign pslverr = err_q & psel & penable;

  assign wr_en    = wr_fire & ~err_q & ~ignore_q;
  assign wr_pmc   = wr_en & ready_q & (paddr == ADDR_PMC);
  assign wr_int   = wr_en & ready_q & (paddr == ADDR_INTERRUPT_STATUS_REG);
  assign wr_phy   = wr_en & ready_q & (paddr == ADDR_PHY_CTRL);
  assign wake_wr  = wr_en & (paddr == ADDR_BYTE_TEST) &
                    ((state_q == pwr_d1) | (state_q == pwr_d2));
  assign req_mode = pwdata[PMC_MODE_LSB +: 2];

  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      ADDR_PMC: begin
        v[PMC_READY_BIT]          = ready_q;
        v[PMC_PME_EN_BIT]         = pme_en_q;
        v[PMC_PULSE_SEL_BIT]      = wake_pin_pulse_select_q;
        v[PMC_WAKE_STATUS_FIELD_LSB +: 2]      = wake_status_field_q;
        v[PMC_WAKE_ON_LAN_ENABLE_BIT]         = wake_on_lan_enable_q;
        v[PMC_ENERGY_DETECT_WAKE_ENABLE_BIT]          = energy_detect_wake_enable_q;
        v[PMC_MODE_LSB +: 2]      = power_mode_q;
      end
      ADDR_BYTE_TEST: v = BYTE_TEST_VALUE;
      ADDR_INTERRUPT_STATUS_REG:   v[INT_PME_BIT] = pme_int_q;
      ADDR_PHY_CTRL:  v[PHY_EDPD_BIT] = edpd_q;
      default:        v = '0;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Power state sequencing
  // Sleep requests count only from D0 with the bus open
  logic enter_d1;
  logic enter_d2;
  logic resume_done;

  assign enter_d1    = (state_q == pwr_d0) & wr_pmc & (req_mode == MODE_D1);
  assign enter_d2    = (state_q == pwr_d0) & wr_pmc & (req_mode == MODE_D2);
  assign resume_done = (state_q == pwr_resume) & (resume_cnt_q == '0);

  // Resume is a state of its own so ready can lag the wake write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pwr_d0;
    end else begin
      case (state_q)
        pwr_d0: begin
          if (enter_d1) begin
            state_q <= pwr_d1;
          end else if (enter_d2) begin
            state_q <= pwr_d2;
          end
        end
        pwr_d1, pwr_d2: begin
          if (wake_wr) begin
            state_q <= pwr_resume;
          end
        end
        pwr_resume: begin
          if (resume_done) begin
            state_q <= pwr_d0;
          end
        end
        default: begin
          state_q <= pwr_d0;
        end
      endcase
    end
  end

  // Ready stays low through the whole resume count
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b1;
    end else if (enter_d1 || enter_d2) begin
      ready_q <= 1'b0;
    end else if (resume_done) begin
      ready_q <= 1'b1;
    end
  end

  // Mode field follows the state and reads 00 in resume
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_mode_q <= MODE_D0;
    end else if (enter_d1) begin
      power_mode_q <= MODE_D1;
    end else if (enter_d2) begin
      power_mode_q <= MODE_D2;
    end else if (wake_wr) begin
      power_mode_q <= MODE_D0;
    end
  end

  // Loaded only by a wake write, so it rests at zero in D0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resume_cnt_q <= '0;
    end else if (wake_wr) begin
      resume_cnt_q <= RESUME_W'(RESUME_LEN - 1);
    end else if (resume_cnt_q != '0) begin
      resume_cnt_q <= resume_cnt_q - 1'b1;
    end
  end

  // Reads re-arm writes after reset and after each wake
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_seen_q <= 1'b0;
    end else if (wake_wr) begin
      read_seen_q <= 1'b0;
    end else if (rd_fire) begin
      read_seen_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Control bits, untouched by sleep entry and exit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_en_q                    <= 1'b0;
      wake_pin_pulse_select_q     <= 1'b0;
      wake_on_lan_enable_q        <= 1'b0;
      energy_detect_wake_enable_q <= 1'b0;
    end else if (wr_pmc) begin
      pme_en_q                    <= pwdata[PMC_PME_EN_BIT];
      wake_pin_pulse_select_q     <= pwdata[PMC_PULSE_SEL_BIT];
      wake_on_lan_enable_q        <= pwdata[PMC_WAKE_ON_LAN_ENABLE_BIT];
      energy_detect_wake_enable_q <= pwdata[PMC_ENERGY_DETECT_WAKE_ENABLE_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      edpd_q <= 1'b0;
    end else if (wr_phy) begin
      edpd_q <= pwdata[PHY_EDPD_BIT];
    end
  end

  assign phy_energy_detect_powerdown = edpd_q;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Wake detection
  logic       detect_wol;
  logic       detect_ed;
  logic [1:0] wake_status_field_set;
  logic [1:0] wake_status_field_clr;
  logic       pme_interrupt;

  assign detect_wol = (state_q == pwr_d1) & (frame_s | magic_s);
  // Level test, so carrier already up at entry fires at once
  assign detect_ed  = (state_q == pwr_d2) & carrier_s;
  assign wake_status_field_set   = (detect_wol ? WAKE_STATUS_FIELD_WOL : WAKE_STATUS_FIELD_NONE) |
                      (detect_ed ? WAKE_STATUS_FIELD_ED : WAKE_STATUS_FIELD_NONE);
  assign wake_status_field_clr   = wr_pmc ? pwdata[PMC_WAKE_STATUS_FIELD_LSB +: 2] : WAKE_STATUS_FIELD_NONE;

  // Set beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_status_field_q <= WAKE_STATUS_FIELD_NONE;
    end else begin
      wake_status_field_q <= wake_status_field_set | (wake_status_field_q & ~wake_status_field_clr);
    end
  end

  assign pme_interrupt = (wake_status_field_q[1] & wake_on_lan_enable_q) |
                         (wake_status_field_q[0] & energy_detect_wake_enable_q);

  // Sticky while the source holds, whatever the PME enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_int_q <= 1'b0;
    end else begin
      pme_int_q <= pme_interrupt | (pme_int_q & ~(wr_int & pwdata[INT_PME_BIT]));
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // PME pin
  // Previous source level for the edge test
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_irq_prev_q <= 1'b0;
    end else begin
      pme_irq_prev_q <= pme_interrupt;
    end
  end

  // Restarts only on a new event edge, so a held source pulses once
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_cnt_q <= '0;
    end else if (pme_interrupt && !pme_irq_prev_q) begin
      pulse_cnt_q <= PULSE_W'(PULSE_CYCLES);
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - 1'b1;
    end
  end

  // Pulse length counts from the event, so a late switch to pulse mode trims it and a late switch to level mode holds it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pme_out_q <= 1'b0;
    end else begin
      pme_out_q <= pme_en_q & pme_interrupt &
                   (~wake_pin_pulse_select_q | (pulse_cnt_q != '0));
    end
  end

  assign pme_out = pme_out_q;

  //////////////////////////////////////////////////////////////////////////////////////////////////
  // Clock gating
  // This block sits in the always-on domain; its own clock never stops
  assign mac_clk_en      = (state_q == pwr_d0);
  assign host_if_clk_en  = (state_q == pwr_d0);
  assign rx_pm_clk_en    = (state_q == pwr_d0) | (state_q == pwr_d1);
  assign internal_clk_en = (state_q != pwr_d2);
  assign phy_full_on     = (state_q != pwr_d2);

endmodule

// ==== host_apb_model.sv ====
module host_apb_model
  import power_state_pkg::*;
(
  input  wire logic              sys_clk,
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Request held until pready, for at most 20 cycles; no fixed wait assumed
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er, output bit ok);
    int n;
    @(posedge sys_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    ok = 0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge sys_clk);
      ok = (pready === 1'b1);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
endmodule

// ==== power_state_wake_control_asserts.sv ====
module power_state_wake_control_asserts
  import power_state_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PME_PULSE_CYCLES,
  parameter int unsigned RESUME_LEN   = RESUME_CYCLES
) (
  input wire logic              sys_clk,
  input wire logic              nrst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              wake_frame_det,
  input wire logic              magic_pkt_det,
  input wire logic              carrier_det,
  input wire logic              pme_out,
  input wire logic              mac_clk_en,
  input wire logic              host_if_clk_en,
  input wire logic              rx_pm_clk_en,
  input wire logic              internal_clk_en,
  input wire logic              phy_full_on,
  input wire logic              phy_energy_detect_powerdown
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int WAKE_MAX = RESUME_LEN + 4;
  logic wr_acc;
  assign wr_acc = psel && penable && pwrite;
  logic [31:0] wake_cnt;
  // Counts from a wake write until the D0 clocks are back
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt <= '0;
    end else if (mac_clk_en) begin
      wake_cnt <= '0;
    end else if (wake_cnt != 0 || (wr_acc && paddr == ADDR_BYTE_TEST)) begin
      wake_cnt <= wake_cnt + 1;
    end
  end
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  err_in_access_a: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  refused_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 0)
    else $error("refused read returned data");
  full_on_a: assert property (mac_clk_en |-> host_if_clk_en && rx_pm_clk_en && internal_clk_en
                              && phy_full_on)
    else $error("partial clock set in D0");
  sleep_by_mode_a: assert property ($fell(mac_clk_en) |-> $past(wr_acc && paddr == ADDR_PMC))
    else $error("sleep without mode write");
  wake_by_test_a: assert property ($rose(internal_clk_en) |->
                                   $past(wr_acc && paddr == ADDR_BYTE_TEST))
    else $error("D2 left without wake write");
  resume_bound_a: assert property (wake_cnt <= WAKE_MAX)
    else $error("ready late after wake");
  d1_keeps_a: assert property (!mac_clk_en && rx_pm_clk_en |->
                               internal_clk_en && phy_full_on && !host_if_clk_en)
    else $error("D1 clock set wrong");
  d2_off_a: assert property (!internal_clk_en |-> !phy_full_on && !mac_clk_en && !rx_pm_clk_en
                             && !host_if_clk_en)
    else $error("D2 clock set wrong");
  edpd_by_write_a: assert property ($changed(phy_energy_detect_powerdown) |->
                                    $past(wr_acc && paddr == ADDR_PHY_CTRL))
    else $error("powerdown bit changed on its own");
  d1_entry_c: cover property ($fell(mac_clk_en) && rx_pm_clk_en);
  d2_entry_c: cover property ($fell(internal_clk_en));
  pme_rise_c: cover property ($rose(pme_out));
endmodule

bind power_state_wake_control power_state_wake_control_asserts #(
  .PULSE_CYCLES(PULSE_CYCLES),
  .RESUME_LEN(RESUME_LEN)
) chk_u (
  .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wake_frame_det(wake_frame_det), .magic_pkt_det(magic_pkt_det), .carrier_det(carrier_det),
  .pme_out(pme_out), .mac_clk_en(mac_clk_en), .host_if_clk_en(host_if_clk_en),
  .rx_pm_clk_en(rx_pm_clk_en), .internal_clk_en(internal_clk_en), .phy_full_on(phy_full_on),
  .phy_energy_detect_powerdown(phy_energy_detect_powerdown)
);

// ==== power_state_wake_control_tb_top.sv ====
module power_state_wake_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import power_state_pkg::*;
  localparam int unsigned PULSE = 20;
  logic              sys_clk = 0;
  logic              nrst = 0;
  logic              wake_frame_det = 0;
  logic              magic_pkt_det = 0;
  logic              carrier_det = 0;
  logic              psel, penable, pwrite, pready, pslverr, pme_out, rerr;
  logic              mac_en, host_en, rx_en, int_en, phy_on, edpd;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;
  int                err_total = 0;
  int                num_checks = 0;
  int                n;
  always #20 sys_clk = ~sys_clk;
  host_apb_model host_u (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Short counts keep the run small
  power_state_wake_control #(.PULSE_CYCLES(PULSE), .RESUME_LEN(5)) dut_u (
    .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_frame_det(wake_frame_det), .magic_pkt_det(magic_pkt_det), .carrier_det(carrier_det),
    .pme_out(pme_out), .mac_clk_en(mac_en), .host_if_clk_en(host_en), .rx_pm_clk_en(rx_en),
    .internal_clk_en(int_en), .phy_full_on(phy_on), .phy_energy_detect_powerdown(edpd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bit ok;
    host_u.xfer(w, a, d, rdat, rerr, ok);
    if (!ok) begin
      chk("pready", 1, 0);
      end_of_test();
    end
  endtask
  task automatic wait_pme();
    for (n = 0; n < 20 && pme_out !== 1'b1; n++) @(negedge sys_clk);
    chk("pme_out", 1, pme_out);
    if (pme_out !== 1'b1) end_of_test();
  endtask
  task automatic wait_ready();
    rdat = 0;
    for (n = 0; n < 20 && rdat[0] !== 1'b1; n++) acc(0, ADDR_PMC, 0);
    chk("ready", 1, rdat[0]);
    if (rdat[0] !== 1'b1) end_of_test();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_reset();
    nrst <= 0;
    repeat (5) @(posedge sys_clk);
    nrst <= 1;
    repeat (3) @(posedge sys_clk);
    acc(1, ADDR_PHY_CTRL, 32'h0000_0001);
    acc(0, ADDR_PMC, 0);
    chk("pmc", 32'h0000_0001, rdat & 32'h0000_3031);
    acc(0, ADDR_PHY_CTRL, 0);
    chk("edpd", 0, rdat);
    acc(0, ADDR_BYTE_TEST, 0);
    chk("byte_test", BYTE_TEST_VALUE, rdat);
    acc(0, 12'h010, 0);
    chk("unmapped err", 1, rerr);
    acc(1, ADDR_PHY_CTRL, 32'h0000_0001);
    acc(0, ADDR_PHY_CTRL, 0);
    chk("edpd", 1, rdat);
  endtask
  task automatic s_d1();
    acc(1, ADDR_PMC, 32'h0000_1202);
    @(negedge sys_clk);
    chk("clk d1", 5'b00111, {mac_en, host_en, rx_en, int_en, phy_on});
    acc(0, ADDR_PMC, 0);
    chk("pmc d1", 32'h0000_1000, rdat & 32'h0000_3031);
    acc(0, ADDR_INTERRUPT_STATUS_REG, 0);
    chk("sleep read", 32'h0000_0001, {rdat[30:0], rerr});
    acc(1, ADDR_PHY_CTRL, 0);
    chk("sleep write err", 1, rerr);
    wake_frame_det <= 1;
    wait_pme();
    acc(0, ADDR_PMC, 0);
    wake_frame_det <= 0;
    chk("wake status", 32'h0000_1020, rdat & 32'h0000_3031);
    acc(1, ADDR_BYTE_TEST, 32'h0000_0000);
    acc(0, ADDR_PMC, 0);
    chk("pmc wake", 32'h0000_0020, rdat & 32'h0000_3031);
    wait_ready();
    acc(0, ADDR_INTERRUPT_STATUS_REG, 0);
    chk("pme int", 1, rdat[0]);
    acc(1, ADDR_PMC, 32'h0000_0232);
    repeat (3) @(negedge sys_clk);
    chk("pme clear", 0, pme_out);
    acc(0, ADDR_PHY_CTRL, 0);
    chk("edpd kept", 1, rdat);
    acc(1, ADDR_INTERRUPT_STATUS_REG, 32'h0000_0001);
  endtask
  task automatic s_magic();
    acc(1, ADDR_PMC, 32'h0000_1200);
    magic_pkt_det <= 1;
    repeat (8) @(negedge sys_clk);
    chk("pme gated", 0, pme_out);
    acc(0, ADDR_PMC, 0);
    magic_pkt_det <= 0;
    chk("magic status", 32'h0000_1020, rdat & 32'h0000_3031);
    acc(1, ADDR_BYTE_TEST, 32'h0000_0000);
    wait_ready();
    acc(0, ADDR_INTERRUPT_STATUS_REG, 0);
    chk("pme int no pin", 1, rdat[0]);
    acc(1, ADDR_PMC, 32'h0000_0020);
    acc(1, ADDR_INTERRUPT_STATUS_REG, 32'h0000_0001);
  endtask
  task automatic s_d2();
    carrier_det <= 1;
    acc(1, ADDR_PMC, 32'h0000_240A);
    @(negedge sys_clk);
    chk("clk d2", 0, {mac_en, host_en, rx_en, int_en, phy_on});
    wait_pme();
    for (n = 0; n < 100 && pme_out === 1'b1; n++) @(negedge sys_clk);
    num_checks++;
    if (n < PULSE || n > PULSE + 1) begin
      err_total++;
      $display("unexpected pulse length: expected %0d seen %0d", PULSE, n);
    end
    if (n >= 100) end_of_test();
    acc(0, ADDR_PMC, 0);
    carrier_det <= 0;
    chk("pmc d2", 32'h0000_2010, rdat & 32'h0000_3031);
    acc(1, ADDR_BYTE_TEST, 32'h0000_FFFF);
    wait_ready();
    acc(1, ADDR_PHY_CTRL, 0);
    acc(1, ADDR_PMC, 32'h0000_0030);
    acc(0, ADDR_PMC, 0);
    chk("pmc d0", 32'h0000_0001, rdat & 32'h0000_3031);
    @(negedge sys_clk);
    chk("clk d0", 5'b11111, {mac_en, host_en, rx_en, int_en, phy_on});
  endtask
  initial begin
    s_reset();
    s_d1();
    s_magic();
    s_d2();
    @(posedge sys_clk);
    s_reset();
    end_of_test();
  end
endmodule
